// >>> rxsr_channel.sv
// one receive channel: fifo, holding register, time-out timer, service requests
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ns
module rxsr_channel #(
   parameter int DEPTH = rxsr_pkg::FIFO_DEPTH,
   parameter logic [7:0] CHANNEL_ID = 8'h00
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   // bit engine
   input wire logic char_valid_i,
   input wire rxsr_pkg::rxsr_char_t char_i,
   // service request
   input wire logic svc_ack_i,
   output logic rx_req_o,
   output logic rx_req_exc_o,
   output logic [7:0] vector_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [3:0] rx_fifo_threshold;
   logic [2:0] request_enable_reg;
   logic [7:0] rx_timeout_period;
   logic [15:0] presc_period;
   logic [15:0] presc_cnt;
   logic [7:0] tmo_cnt;
   rxsr_pkg::rxsr_entry_t mem [DEPTH];
   rxsr_pkg::rxsr_entry_t hold;
   rxsr_pkg::rxsr_entry_t in_entry;
   rxsr_pkg::rxsr_entry_t head;
   rxsr_pkg::rxsr_ctx_t ctx;
   logic hold_valid;
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] idx;
   logic [CW-1:0] count;
   logic [CW-1:0] good_run;
   logic [CW-1:0] thr_eff;
   logic stop;
   logic fifo_space;
   logic push;
   logic pop_read;
   logic pop_eos;
   logic pop;
   logic emptied;
   logic tick;
   logic expire;
   logic stale;
   logic idle_tmo_armed;
   logic idle_tmo_pend;
   logic exc_head;
   logic idle_tmo_cond;
   logic good_cond;
   logic eos_wr;
   logic [1:0] holdoff;

   // register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_fifo_threshold <= rxsr_pkg::OPT3_RST;
         request_enable_reg <= rxsr_pkg::REQEN_RST;
         rx_timeout_period <= rxsr_pkg::TMO_RST;
         presc_period <= rxsr_pkg::PRESC_RST;
      end else if (we_i) begin
         if (addr_i == rxsr_pkg::OFF_CHAN_OPT3) begin
            rx_fifo_threshold <= wdata_i[3:0];
         end else if (addr_i == rxsr_pkg::OFF_REQ_EN) begin
            request_enable_reg <= wdata_i[2:0];
         end else if (addr_i == rxsr_pkg::OFF_TMO) begin
            rx_timeout_period <= wdata_i;
         end else if (addr_i == rxsr_pkg::OFF_PRESC_LO) begin
            presc_period[7:0] <= wdata_i;
         end else if (addr_i == rxsr_pkg::OFF_PRESC_HI) begin
            presc_period[15:8] <= wdata_i;
         end
      end
   end

   assign eos_wr = we_i && (addr_i == rxsr_pkg::OFF_EOSR);

   // incoming char with its status; special only flagged when special requests enabled
   always_comb begin
      in_entry = '0;
      in_entry.data = char_i.data;
      in_entry.stat[rxsr_pkg::ST_PARITY] = char_i.parity_err;
      in_entry.stat[rxsr_pkg::ST_FRAMING] = char_i.framing_err;
      in_entry.stat[rxsr_pkg::ST_BREAK] = char_i.brk;
      in_entry.stat[rxsr_pkg::ST_SPECIAL] = char_i.special
         && request_enable_reg[rxsr_pkg::REQEN_SPECIAL];
   end

   assign head = mem[rd_ptr];
   assign fifo_space = count < CW'(DEPTH);
   assign push = (hold_valid || char_valid_i) && fifo_space;
   assign pop_read = re_i && (addr_i == rxsr_pkg::OFF_RDATA) && (ctx == rxsr_pkg::CTX_GOOD)
      && (good_run != '0);
   assign pop_eos = eos_wr && (ctx == rxsr_pkg::CTX_EXC) && (count != '0);
   assign pop = pop_read || pop_eos;
   assign emptied = pop && !push && (count == CW'(1));

   // holding register in front of the fifo
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_valid <= 1'b0;
         hold <= '0;
      end else if (hold_valid) begin
         if (push) begin
            hold_valid <= char_valid_i;
            hold <= in_entry;
         end else if (char_valid_i) begin
            hold.stat[rxsr_pkg::ST_OVERRUN] <= 1'b1;
         end
      end else if (char_valid_i && !fifo_space) begin
         hold_valid <= 1'b1;
         hold <= in_entry;
      end
   end

   // fifo storage; depth must be a power of two for pointer wrap
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= hold_valid ? hold : in_entry;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

   // run of good chars from the head up to the first exception
   always_comb begin
      good_run = '0;
      stop = 1'b0;
      idx = '0;
      for (int i = 0; i < DEPTH; i++) begin
         idx = PW'(int'(rd_ptr) + i);
         if (!stop && (i < int'(count)) && (mem[idx].stat == '0)) begin
            good_run = good_run + 1'b1;
         end else begin
            stop = 1'b1;
         end
      end
   end

   // prescaler tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_cnt <= '0;
      end else if (presc_cnt == '0 || presc_cnt > presc_period) begin
         // a shortened period takes hold at once, not after the old count
         presc_cnt <= presc_period;
      end else begin
         presc_cnt <= presc_cnt - 1'b1;
      end
   end

   assign tick = (presc_cnt == '0);

   // receive time-out counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmo_cnt <= '0;
      end else if (push) begin
         tmo_cnt <= rx_timeout_period;
      end else if (tick && tmo_cnt != '0) begin
         tmo_cnt <= tmo_cnt - 1'b1;
      end
   end

   assign expire = !push && tick && (tmo_cnt == 8'h01);

   // stale data flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stale <= 1'b0;
      end else if (expire && good_run != '0) begin
         stale <= 1'b1;
      end else if (push || pop_read) begin
         stale <= 1'b0;
      end
   end

   // no-new-data arming and pending exception
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_tmo_armed <= 1'b0;
      end else if (emptied) begin
         idle_tmo_armed <= 1'b1;
      end else if (expire && count == '0) begin
         idle_tmo_armed <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_tmo_pend <= 1'b0;
      end else if (expire && count == '0 && idle_tmo_armed
            && request_enable_reg[rxsr_pkg::REQEN_IDLE_TMO]) begin
         idle_tmo_pend <= 1'b1;
      end else if (eos_wr && ctx == rxsr_pkg::CTX_IDLE_TMO) begin
         idle_tmo_pend <= 1'b0;
      end
   end

   // effective threshold, clamped to one..depth
   always_comb begin
      if (rx_fifo_threshold == '0) begin
         thr_eff = CW'(1);
      end else if (int'(rx_fifo_threshold) > DEPTH) begin
         thr_eff = CW'(DEPTH);
      end else begin
         thr_eff = CW'(rx_fifo_threshold);
      end
   end

   // request conditions, decided by the head so arrival order is kept
   assign exc_head = (count != '0) && (head.stat != '0);
   assign idle_tmo_cond = (count == '0) && idle_tmo_pend;
   assign good_cond = (good_run != '0) && ((count >= thr_eff)
      || stale
      || (good_run != count));

   assign rx_req_o = request_enable_reg[rxsr_pkg::REQEN_RXD]
      && (ctx == rxsr_pkg::CTX_IDLE) && (holdoff == '0)
      && (exc_head || idle_tmo_cond || good_cond);
   assign rx_req_exc_o = rx_req_o && (exc_head || idle_tmo_cond);

   // service context
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctx <= rxsr_pkg::CTX_IDLE;
         vector_o <= rxsr_pkg::VEC_NONE;
      end else begin
         case (ctx)
            rxsr_pkg::CTX_IDLE: begin
               if (svc_ack_i) begin
                  if (!rx_req_o) begin
                     vector_o <= rxsr_pkg::VEC_NONE;
                  end else if (exc_head) begin
                     ctx <= rxsr_pkg::CTX_EXC;
                     vector_o <= rxsr_pkg::VEC_EXC;
                  end else if (idle_tmo_cond) begin
                     ctx <= rxsr_pkg::CTX_IDLE_TMO;
                     vector_o <= rxsr_pkg::VEC_EXC;
                  end else begin
                     ctx <= rxsr_pkg::CTX_GOOD;
                     vector_o <= rxsr_pkg::VEC_GOOD;
                  end
               end
            end
            default: begin
               if (eos_wr) begin
                  ctx <= rxsr_pkg::CTX_IDLE;
               end
            end
         endcase
      end
   end

   // hold-off after end of service
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         holdoff <= '0;
      end else if (eos_wr && ctx != rxsr_pkg::CTX_IDLE) begin
         holdoff <= rxsr_pkg::HOLDOFF_CYCLES;
      end else if (holdoff != '0) begin
         holdoff <= holdoff - 1'b1;
      end
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (re_i) begin
         if (addr_i == rxsr_pkg::OFF_CHAN_OPT3) begin
            rdata_o <= {4'h0, rx_fifo_threshold};
         end else if (addr_i == rxsr_pkg::OFF_REQ_EN) begin
            rdata_o <= {5'h00, request_enable_reg};
         end else if (addr_i == rxsr_pkg::OFF_TMO) begin
            rdata_o <= rx_timeout_period;
         end else if (addr_i == rxsr_pkg::OFF_PRESC_LO) begin
            rdata_o <= presc_period[7:0];
         end else if (addr_i == rxsr_pkg::OFF_PRESC_HI) begin
            rdata_o <= presc_period[15:8];
         end else if (addr_i == rxsr_pkg::OFF_REQ_STAT) begin
            rdata_o <= {5'h00, ctx != rxsr_pkg::CTX_IDLE, rx_req_exc_o, rx_req_o};
         end else if (addr_i == rxsr_pkg::OFF_RDATA) begin
            if (pop_read || (ctx == rxsr_pkg::CTX_EXC && count != '0)) begin
               rdata_o <= head.data;
            end else begin
               rdata_o <= '0;
            end
         end else if (addr_i == rxsr_pkg::OFF_RSTAT) begin
            if (ctx == rxsr_pkg::CTX_IDLE_TMO) begin
               rdata_o <= 8'h20; // time-out status only
            end else if ((ctx == rxsr_pkg::CTX_EXC || ctx == rxsr_pkg::CTX_GOOD)
                  && count != '0) begin
               rdata_o <= {2'h0, head.stat};
            end else begin
               rdata_o <= '0;
            end
         end else if (addr_i == rxsr_pkg::OFF_RCNT) begin
            rdata_o <= (ctx == rxsr_pkg::CTX_GOOD) ? 8'(good_run) : 8'h00;
         end else if (addr_i == rxsr_pkg::OFF_CHAN_ID) begin
            rdata_o <= CHANNEL_ID;
         end else begin
            rdata_o <= '0;
         end
      end else begin
         rdata_o <= '0;
      end
   end
endmodule

// >>> rxsr_pkg.sv
// constants, register map and types for the receive fifo service request block
package rxsr_pkg;
   localparam int FIFO_DEPTH = 8;
   // register offsets
   localparam logic [7:0] OFF_CHAN_OPT3 = 8'h00;
   localparam logic [7:0] OFF_REQ_EN = 8'h04;
   localparam logic [7:0] OFF_TMO = 8'h08;
   localparam logic [7:0] OFF_PRESC_LO = 8'h0C;
   localparam logic [7:0] OFF_PRESC_HI = 8'h10;
   localparam logic [7:0] OFF_REQ_STAT = 8'h14;
   localparam logic [7:0] OFF_EOSR = 8'h18;
   localparam logic [7:0] OFF_RDATA = 8'h1C;
   localparam logic [7:0] OFF_RSTAT = 8'h20;
   localparam logic [7:0] OFF_RCNT = 8'h24;
   localparam logic [7:0] OFF_CHAN_ID = 8'h28;
   // request enable bit positions
   localparam int REQEN_RXD = 0;
   localparam int REQEN_IDLE_TMO = 1;
   localparam int REQEN_SPECIAL = 2;
   // status bit positions
   localparam int ST_PARITY = 0;
   localparam int ST_FRAMING = 1;
   localparam int ST_BREAK = 2;
   localparam int ST_SPECIAL = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_TIMEOUT = 5;
   // reset values
   localparam logic [3:0] OPT3_RST = 4'h1;
   localparam logic [2:0] REQEN_RST = 3'h0;
   localparam logic [7:0] TMO_RST = 8'h00;
   localparam logic [15:0] PRESC_RST = 16'hFFFF;
   // cycles the request stays low after end of service
   localparam logic [1:0] HOLDOFF_CYCLES = 2'h2;
   // vectors returned at acknowledge
   localparam logic [7:0] VEC_NONE = 8'h00;
   localparam logic [7:0] VEC_GOOD = 8'h01;
   localparam logic [7:0] VEC_EXC = 8'h02;

   typedef enum logic [1:0] {
      CTX_IDLE = 2'b00,
      CTX_GOOD = 2'b01,
      CTX_EXC = 2'b10,
      CTX_IDLE_TMO = 2'b11
   } rxsr_ctx_t;

   typedef struct packed {
      logic special;
      logic brk;
      logic framing_err;
      logic parity_err;
      logic [7:0] data;
   } rxsr_char_t;

   typedef struct packed {
      logic [5:0] stat;
      logic [7:0] data;
   } rxsr_entry_t;
endpackage

// >>> rxsr_channel_sva.sv
// assertions on the receive channel ports
`timescale 1ns/1ns
module rxsr_channel_sva #(
   parameter logic [7:0] CHANNEL_ID = 8'h00
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [7:0] rdata_o,
   // service request
   input wire logic svc_ack_i,
   input wire logic rx_req_o,
   input wire logic rx_req_exc_o,
   input wire logic [7:0] vector_o
);
   logic in_svc;
   logic rxd_en;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // service context as the host sees it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_svc <= 1'b0;
      end else if (we_i && addr_i == rxsr_pkg::OFF_EOSR) begin
         in_svc <= 1'b0;
      end else if (svc_ack_i && rx_req_o) begin
         in_svc <= 1'b1;
      end
   end
   // shadow of the receive data enable bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxd_en <= 1'b0;
      end else if (we_i && addr_i == rxsr_pkg::OFF_REQ_EN) begin
         rxd_en <= wdata_i[rxsr_pkg::REQEN_RXD];
      end
   end
   sequence eos_wr;
      we_i && addr_i == rxsr_pkg::OFF_EOSR && in_svc;
   endsequence
   sequence req_quiet;
      !rx_req_o [*2];
   endsequence
   sequence good_ack;
      svc_ack_i && rx_req_o && !rx_req_exc_o;
   endsequence
   sequence exc_ack;
      svc_ack_i && rx_req_o && rx_req_exc_o;
   endsequence
   holdoff_quiet_a: assert property (eos_wr |=> req_quiet)
      else $error("request rose inside the holdoff");
   exc_subtype_a: assert property (rx_req_exc_o |-> rx_req_o)
      else $error("exception flag without request");
   good_vector_a: assert property (good_ack |=> vector_o == rxsr_pkg::VEC_GOOD && !rx_req_o)
      else $error("valid data vector wrong");
   exc_vector_a: assert property (exc_ack |=> vector_o == rxsr_pkg::VEC_EXC)
      else $error("exception vector wrong");
   bad_ack_a: assert property (svc_ack_i && !rx_req_o && !in_svc |=> vector_o == 8'h00)
      else $error("vector given without request");
   req_enable_a: assert property (rx_req_o |-> rxd_en)
      else $error("request while disabled");
   data_outside_a: assert property (re_i && !in_svc && (addr_i == rxsr_pkg::OFF_RDATA
      || addr_i == rxsr_pkg::OFF_RSTAT) |=> rdata_o == 8'h00)
      else $error("fifo read outside service");
   svc_quiet_a: assert property (in_svc |-> !rx_req_o)
      else $error("request high during service");
   chan_id_a: assert property (re_i && addr_i == rxsr_pkg::OFF_CHAN_ID |=> rdata_o == CHANNEL_ID)
      else $error("channel id read wrong");
endmodule
bind rxsr_channel rxsr_channel_sva #(.CHANNEL_ID(CHANNEL_ID)) rxsr_channel_sva_inst (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
   .rdata_o(rdata_o), .svc_ack_i(svc_ack_i), .rx_req_o(rx_req_o), .rx_req_exc_o(rx_req_exc_o),
   .vector_o(vector_o));

// >>> rxsr_host.sv
// host processor model: register accesses and request acknowledge
`timescale 1ns/1ns
module rxsr_host (
   // clock
   input wire logic clk_i,
   // register port and acknowledge
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic we_o,
   output logic re_o,
   output logic ack_o
);
   logic [7:0] exp_q [$];
   initial begin
      addr_o = 8'hff;
      wdata_o = 8'h00;
      we_o = 1'b0;
      re_o = 1'b0;
      ack_o = 1'b0;
   end
   // released address shows its inverse, never the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= v;
      we_o <= 1'b1;
      @(posedge clk_i);
      we_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~v;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_o <= a;
      re_o <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_i);
      re_o <= 1'b0;
      addr_o <= ~a;
   endtask
   // answers promptly or after a few idle cycles
   task automatic ack();
      repeat ($urandom_range(3)) @(posedge clk_i);
      @(posedge clk_i);
      ack_o <= 1'b1;
      @(posedge clk_i);
      ack_o <= 1'b0;
   endtask
endmodule

// >>> tb.sv
// self-checking testbench of the receive channel
`timescale 1ns/1ns
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i, wdata_i, rdata_o, vector_o;
   logic we_i, re_i, svc_ack_i, rx_req_o, rx_req_exc_o;
   logic char_valid_i = 1'b0;
   logic rd_pend = 1'b0;
   rxsr_pkg::rxsr_char_t char_i = '0;
   int err_total = 0;
   int checks = 0;
   logic [7:0] d [0:9];
   always #4 clk_i = ~clk_i;
   rxsr_channel #(.CHANNEL_ID(8'h5a)) rxsr_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
      .char_valid_i(char_valid_i), .char_i(char_i), .svc_ack_i(svc_ack_i), .rx_req_o(rx_req_o),
      .rx_req_exc_o(rx_req_exc_o), .vector_o(vector_o));
   rxsr_host rxsr_host_inst (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .we_o(we_i),
      .re_o(re_i), .ack_o(svc_ack_i));
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (rd_pend) chk("rdata", rdata_o, rxsr_host_inst.exp_q.pop_front());
      rd_pend <= re_i;
   end
   task automatic send(input logic [3:0] f, input logic [7:0] v);
      @(posedge clk_i);
      char_valid_i <= 1'b1;
      char_i <= {f, v};
      @(posedge clk_i);
      char_valid_i <= 1'b0;
      char_i <= {~f, ~v};
   endtask
   task automatic serve(input logic exc);
      int n;
      n = 0;
      while (rx_req_o !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("request", {6'h0, rx_req_exc_o, rx_req_o}, {6'h0, exc, 1'b1});
      rxsr_host_inst.ack();
      #1 chk("vector", vector_o, exc ? rxsr_pkg::VEC_EXC : rxsr_pkg::VEC_GOOD);
   endtask
   task automatic eos();
      rxsr_host_inst.wr(rxsr_pkg::OFF_EOSR, 8'h00);
   endtask
   initial begin
      repeat (10000) @(posedge clk_i);
      err_total++;
      results();
   end
   initial begin
      void'($urandom(32'hfa20));
      for (int i = 0; i < 10; i++) d[i] = 8'($urandom);
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rxsr_host_inst.rd(rxsr_pkg::OFF_CHAN_OPT3, 8'h01);
      rxsr_host_inst.rd(rxsr_pkg::OFF_PRESC_HI, 8'hff);
      rxsr_host_inst.rd(8'h30, 8'h00);
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h01);
      rxsr_host_inst.wr(rxsr_pkg::OFF_CHAN_OPT3, 8'h03);
      for (int i = 0; i < 3; i++) begin
         send(4'h0, d[i]);
         if (i == 1) rxsr_host_inst.rd(rxsr_pkg::OFF_REQ_STAT, 8'h00);
         if (i == 1) rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, 8'h00);
      end
      serve(1'b0);
      for (int i = 0; i < 3; i++) rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[i]);
      eos();
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h00);
      for (int i = 0; i < 3; i++) send(4'h0, d[i]);
      #1 chk("req_off", {7'h0, rx_req_o}, 8'h00);
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h01);
      serve(1'b0);
      eos();
      #1 chk("holdoff1", {7'h0, rx_req_o}, 8'h00);
      @(posedge clk_i);
      #1 chk("holdoff2", {7'h0, rx_req_o}, 8'h00);
      @(posedge clk_i);
      #1 chk("reassert", {7'h0, rx_req_o}, 8'h01);
      serve(1'b0);
      for (int i = 0; i < 3; i++) rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[i]);
      eos();
      rxsr_host_inst.wr(rxsr_pkg::OFF_CHAN_OPT3, 8'h08);
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h05);
      // parity, framing, break and special, each after one good byte
      for (int k = 0; k < 4; k++) begin
         send(4'h0, d[k]);
         send(4'(1 << k), d[k + 4]);
         serve(1'b0);
         rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[k]);
         eos();
         serve(1'b1);
         rxsr_host_inst.rd(rxsr_pkg::OFF_CHAN_ID, 8'h5a);
         rxsr_host_inst.rd(rxsr_pkg::OFF_RSTAT, 8'(1 << k));
         rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[k + 4]);
         rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[k + 4]);
         eos();
         rxsr_host_inst.rd(rxsr_pkg::OFF_REQ_STAT, 8'h00);
      end
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h00);
      for (int i = 0; i < 10; i++) send(4'h0, d[i]);
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h01);
      serve(1'b0);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RCNT, 8'h08);
      for (int i = 0; i < 8; i++) rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[i]);
      eos();
      serve(1'b1);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RSTAT, 8'h10);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[8]);
      eos();
      // tick every third cycle, far below a real host's tick, keeps the run short
      rxsr_host_inst.wr(rxsr_pkg::OFF_PRESC_LO, 8'h02);
      rxsr_host_inst.wr(rxsr_pkg::OFF_PRESC_HI, 8'h00);
      rxsr_host_inst.wr(rxsr_pkg::OFF_TMO, 8'h08);
      rxsr_host_inst.wr(rxsr_pkg::OFF_REQ_EN, 8'h03);
      send(4'h0, d[9]);
      serve(1'b0);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[9]);
      eos();
      // threshold of one: fifo emptied well before the timer runs out
      rxsr_host_inst.wr(rxsr_pkg::OFF_CHAN_OPT3, 8'h01);
      send(4'h0, d[0]);
      serve(1'b0);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, d[0]);
      eos();
      serve(1'b1);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RSTAT, 8'h20);
      rxsr_host_inst.rd(rxsr_pkg::OFF_RDATA, 8'h00);
      eos();
      repeat (100) @(posedge clk_i);
      #1 chk("single_idle_tmo", {7'h0, rx_req_o}, 8'h00);
      rxsr_host_inst.ack();
      #1 chk("bad_ack", vector_o, rxsr_pkg::VEC_NONE);
      results();
   end
endmodule
